// >>> common/usr_params.svh
// Register indices, field positions, reset values, interrupt vector and last bit indices of words
`ifndef USR_PARAMS_SVH
`define USR_PARAMS_SVH

// Register indices; byte address is four times the index
`define USR_IDX_INTCTL 8'h0b
`define USR_IDX_PIRF 8'h0c
`define USR_IDX_RSTAT 8'h18
`define USR_IDX_RDATA 8'h1a
`define USR_IDX_PIEN 8'h8c
`define USR_IDX_TSTAT 8'h98
`define USR_IDX_BAUD 8'h99
`define USR_IDX_EVST 8'h20
`define USR_IDX_EVCLR 8'h21
`define USR_IDX_EVEN 8'h22

// Field positions
`define USR_B_GIE 7
`define USR_B_PERIPHERAL_IRQ_ENABLE 6
`define USR_B_RECEIVE_IRQ_FLAG 5
`define USR_B_RECEIVE_IRQ_ENABLE 5
`define USR_B_SERIAL_PORT_ENABLE 7
`define USR_B_RX9 6
`define USR_B_SINGLE_RECEIVE_ENABLE 5
`define USR_B_CONTINUOUS_RECEIVE_ENABLE 4
`define USR_B_FRAMING_ERROR_FLAG 2
`define USR_B_OVERRUN_ERROR_FLAG 1
`define USR_B_RECEIVED_NINTH_BIT 0
`define USR_B_CLOCK_SOURCE_SELECT 7
`define USR_B_SYNC 4
`define USR_EV_WORD 0
`define USR_EV_OVR 1

// Writable masks and reset values
`define USR_PIRF_RW 8'hdf
`define USR_RSTAT_RW 8'hf8
`define USR_TSTAT_RW 8'hf5
`define USR_TSTAT_RO 8'h02
`define USR_RST_REG 8'h00
`define USR_RST_TSTAT 8'h02

// Core interrupt vector and last bit indices of 8- and 9-bit words
`define USR_IRQ_VECTOR 13'h0004
`define USR_LAST8 4'h7
`define USR_LAST9 4'h8

`endif

// >>> common/usr_pkg.sv
// Types shared by the receive path modules
package usr_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } usr_bus_t;

  typedef struct packed {
    usr_bus_t bus;
    logic waitReq;
    logic [31:0] rdata;
    logic [7:0] intCtl;
    logic [7:0] pirf;
    logic [7:0] rstat;
    logic [7:0] pien;
    logic [7:0] tstat;
    logic [7:0] baud;
    logic overrun_error_flag;
    logic [1:0] evStat;
    logic [1:0] evEn;
    logic irq;
    logic coreIrq;
    logic wake;
    logic [12:0] vector;
  } usr_state_t;

  typedef struct packed {
    logic [2:0] ck;
    logic [1:0] dt;
    logic [8:0] sh;
    logic [3:0] cnt;
    logic vld;
    logic [8:0] word;
  } usr_shift_t;

endpackage : usr_pkg

// >>> common/usr_word_if.sv
// Completed-word hand-off from the shifter to the register block
`timescale 1ns/10ps
interface usr_word_if;
  logic vld;
  logic [8:0] word;
  logic framing_error_flag;
  modport src (output vld, output word, output framing_error_flag);
  modport snk (input vld, input word, input framing_error_flag);
endinterface : usr_word_if

// >>> verilog/usr_rx_shift.sv
// Link sampler and receive shifter
`timescale 1ns/10ps
`include "usr_params.svh"

module usr_rx_shift
  import usr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic en,
  input wire logic nine,
  input wire logic linkClk,
  input wire logic linkData,
  usr_word_if.src wOut
);

  usr_shift_t s;
  usr_shift_t next_s;
  logic fall;

  assign fall = s.ck[2] & ~s.ck[1];
  assign wOut.vld = s.vld;
  assign wOut.word = s.word;
  // No stop bit in synchronous mode, so no framing error
  assign wOut.framing_error_flag = 1'b0;

  always_comb begin
    next_s = s;
    next_s.ck = {s.ck[1:0], linkClk};
    next_s.dt = {s.dt[0], linkData};
    next_s.vld = 1'b0;
    if (!en) begin
      next_s.sh = '0;
      next_s.cnt = '0;
    end else if (fall) begin
      next_s.sh[s.cnt] = s.dt[1];
      if (s.cnt == (nine ? `USR_LAST9 : `USR_LAST8)) begin
        next_s.vld = 1'b1;
        next_s.word = next_s.sh;
        next_s.sh = '0;
        next_s.cnt = '0;
      end else begin
        next_s.cnt = s.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  eight_bit_word_a: assert property (ce && en && fall && !nine
    && s.cnt == `USR_LAST8 |=> !s.word[8])
    else $error("ninth bit set in 8-bit mode");
  idle_when_off_a: assert property (ce && !en |=> s.cnt == 4'h0 && !s.vld)
    else $error("shifter active while reception disabled");

endmodule : usr_rx_shift

// >>> verilog/usr_rx_fifo.sv
// Receive buffer holding data word and status per entry
`timescale 1ns/10ps

module usr_rx_fifo #(
  parameter int W = 10,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic push,
  input wire logic [W-1:0] din,
  input wire logic pop,
  output logic [W-1:0] dout,
  output logic full,
  output logic empty
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [CW-1:0] cnt;
  } usr_fifo_t;

  usr_fifo_t s;
  usr_fifo_t next_s;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : bump

  assign dout = s.mem[s.rd];
  assign full = (s.cnt == CW'(DEPTH));
  assign empty = (s.cnt == '0);

  always_comb begin
    next_s = s;
    if (push && !full) begin
      next_s.mem[s.wr] = din;
      next_s.wr = bump(s.wr);
    end
    if (pop && !empty) begin
      next_s.rd = bump(s.rd);
    end
    next_s.cnt = s.cnt + CW'(push && !full) - CW'(pop && !empty);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  no_push_full_a: assert property (push |-> !full)
    else $error("push into full receive buffer");

endmodule : usr_rx_fifo

// >>> verilog/usr_sync_rx.sv
// Synchronous slave receive path with Avalon-MM registers and interrupts
`timescale 1ns/10ps
`include "usr_params.svh"

module usr_sync_rx
  import usr_pkg::*;
#(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic linkClk,
  input wire logic linkData,
  input wire logic sleepIn,
  output logic irq,
  output logic coreIrq,
  output logic wakeOut,
  output logic [12:0] irqVector
);

  //--------------------------------------------------------------
  // State and local signals
  //--------------------------------------------------------------
  localparam usr_state_t RST = '{
    bus: BUS_IDLE,
    waitReq: 1'b1,
    tstat: `USR_RST_TSTAT,
    default: '0
  };

  usr_state_t s;
  usr_state_t next_s;
  usr_word_if wIf ();
  logic [7:0] idx;
  logic active;
  logic acc;
  logic push;
  logic ovr;
  logic pop;
  logic full;
  logic empty;
  logic receive_irq_flag;
  logic [9:0] head;
  logic [1:0] ev;
  logic [1:0] clr;
  logic [7:0] wd;

  //--------------------------------------------------------------
  // Read decode
  //--------------------------------------------------------------
  function automatic logic [7:0] rdMux(
    input usr_state_t st,
    input logic [7:0] i,
    input logic [9:0] hd,
    input logic emp
  );
    logic [7:0] r;
    r = `USR_RST_REG;
    case (i)
      `USR_IDX_INTCTL: r = st.intCtl;
      `USR_IDX_PIRF: begin
        r = st.pirf;
        r[`USR_B_RECEIVE_IRQ_FLAG] = ~emp;
      end
      `USR_IDX_RSTAT: begin
        r = st.rstat;
        r[`USR_B_FRAMING_ERROR_FLAG] = hd[9] & ~emp;
        r[`USR_B_OVERRUN_ERROR_FLAG] = st.overrun_error_flag;
        r[`USR_B_RECEIVED_NINTH_BIT] = hd[8] & ~emp & st.rstat[`USR_B_RX9];
      end
      `USR_IDX_RDATA: r = emp ? `USR_RST_REG : hd[7:0];
      `USR_IDX_PIEN: r = st.pien;
      `USR_IDX_TSTAT: r = st.tstat;
      `USR_IDX_BAUD: r = st.baud;
      `USR_IDX_EVST: r = {6'h00, st.evStat};
      `USR_IDX_EVEN: r = {6'h00, st.evEn};
      default: r = `USR_RST_REG;
    endcase
    rdMux = r;
  endfunction : rdMux

  //--------------------------------------------------------------
  // Receive datapath
  //--------------------------------------------------------------
  // Single-receive enable is stored but never read here
  assign active = s.rstat[`USR_B_SERIAL_PORT_ENABLE] & s.tstat[`USR_B_SYNC]
    & ~s.tstat[`USR_B_CLOCK_SOURCE_SELECT] & s.rstat[`USR_B_CONTINUOUS_RECEIVE_ENABLE];

  usr_rx_shift u_shift (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .en(active),
    .nine(s.rstat[`USR_B_RX9]),
    .linkClk(linkClk),
    .linkData(linkData),
    .wOut(wIf)
  );

  // Overrun discards the word and blocks further transfers
  assign push = wIf.vld & ~s.overrun_error_flag & ~full;
  assign ovr = wIf.vld & ~s.overrun_error_flag & full;

  assign idx = avs_address[9:2];
  assign acc = (s.bus == BUS_ACK);
  assign wd = avs_writedata[7:0];
  assign pop = acc & avs_read & (idx == `USR_IDX_RDATA) & ~empty;
  assign receive_irq_flag = ~empty;

  usr_rx_fifo #(
    .W(10),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .push(push),
    .din({wIf.framing_error_flag, wIf.word}),
    .pop(pop),
    .dout(head),
    .full(full),
    .empty(empty)
  );

  //--------------------------------------------------------------
  // Next state
  //--------------------------------------------------------------
  always_comb begin
    next_s = s;
    clr = 2'b00;
    ev = 2'b00;
    ev[`USR_EV_WORD] = push;
    ev[`USR_EV_OVR] = ovr;
    case (s.bus)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_s.bus = BUS_ACK;
          next_s.waitReq = 1'b0;
          next_s.rdata = {24'h000000, rdMux(s, idx, head, empty)};
        end
      end
      BUS_ACK: begin
        next_s.bus = BUS_IDLE;
        next_s.waitReq = 1'b1;
        if (avs_write && avs_byteenable[0]) begin
          case (idx)
            `USR_IDX_INTCTL: next_s.intCtl = wd;
            `USR_IDX_PIRF: next_s.pirf = wd & `USR_PIRF_RW;
            `USR_IDX_RSTAT: next_s.rstat = wd & `USR_RSTAT_RW;
            `USR_IDX_PIEN: next_s.pien = wd;
            `USR_IDX_TSTAT: next_s.tstat = (wd & `USR_TSTAT_RW) | `USR_TSTAT_RO;
            `USR_IDX_BAUD: next_s.baud = wd;
            `USR_IDX_EVCLR: clr = wd[1:0];
            `USR_IDX_EVEN: next_s.evEn = wd[1:0];
            default: ;
          endcase
        end
      end
      default: begin
        next_s.bus = BUS_IDLE;
        next_s.waitReq = 1'b1;
      end
    endcase
    // Overrun: clearing receive enable clears it, a new overrun wins
    if (!next_s.rstat[`USR_B_CONTINUOUS_RECEIVE_ENABLE]) begin
      next_s.overrun_error_flag = 1'b0;
    end
    if (ovr) begin
      next_s.overrun_error_flag = 1'b1;
    end
    next_s.evStat = (s.evStat & ~clr) | ev;
    next_s.irq = |(s.evStat & s.evEn);
    next_s.coreIrq = s.intCtl[`USR_B_GIE] & s.intCtl[`USR_B_PERIPHERAL_IRQ_ENABLE]
      & s.pien[`USR_B_RECEIVE_IRQ_ENABLE] & receive_irq_flag;
    next_s.wake = sleepIn & s.pien[`USR_B_RECEIVE_IRQ_ENABLE] & receive_irq_flag;
    next_s.vector = next_s.coreIrq ? `USR_IRQ_VECTOR : 13'h0000;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = s.waitReq;
  assign irq = s.irq;
  assign coreIrq = s.coreIrq;
  assign wakeOut = s.wake;
  assign irqVector = s.vector;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence reqTaken;
    ce && (avs_read || avs_write) && s.bus == BUS_IDLE;
  endsequence

  sequence ackCycle;
    !avs_waitrequest ##1 (!ce || avs_waitrequest);
  endsequence

  bus_answer_a: assert property (reqTaken |=> ackCycle)
    else $error("bus request not answered in one wait cycle");
  overrun_set_a: assert property (ce && wIf.vld && full && !s.overrun_error_flag |=> s.overrun_error_flag)
    else $error("overrun not flagged on word into full buffer");
  overrun_block_a: assert property (ce && s.overrun_error_flag && empty |=> empty)
    else $error("transfer into buffer during overrun");
  continuous_receive_enable_clear_a: assert property (ce && !s.rstat[`USR_B_CONTINUOUS_RECEIVE_ENABLE] && !ovr |=> !s.overrun_error_flag)
    else $error("overrun kept with receive disabled");
  word_flag_a: assert property (ce && push |=> receive_irq_flag)
    else $error("receive flag not set after word");
  core_gate_a: assert property (ce && !s.intCtl[`USR_B_GIE] |=> !coreIrq)
    else $error("core interrupt without global enable");
  core_irq_a: assert property (ce && s.intCtl[`USR_B_GIE] && s.intCtl[`USR_B_PERIPHERAL_IRQ_ENABLE]
    && s.pien[`USR_B_RECEIVE_IRQ_ENABLE] && receive_irq_flag |=> coreIrq)
    else $error("enabled receive interrupt missing");
  wake_a: assert property (ce && sleepIn && s.pien[`USR_B_RECEIVE_IRQ_ENABLE] && receive_irq_flag |=> wakeOut)
    else $error("no wake on receive interrupt in sleep");
  vector_a: assert property (coreIrq |-> irqVector == `USR_IRQ_VECTOR)
    else $error("wrong interrupt vector");
  flag_clear_a: assert property (ce && pop && !push && !full |=> !receive_irq_flag)
    else $error("receive flag still set after last word read");
  mode_gate_a: assert property (!s.tstat[`USR_B_SYNC] || s.tstat[`USR_B_CLOCK_SOURCE_SELECT]
    |-> !active)
    else $error("receiver active outside slave mode");

endmodule : usr_sync_rx

// >>> bench/usr_link_master.sv
// Model of the external master that drives the shift clock and serial data
`timescale 1ns/10ps

module usr_link_master (
  output logic linkClk,
  output logic linkData
);
  initial begin
    linkClk = 1'b0;
    linkData = 1'b1;
  end

  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  // Clock stands low between frames; data then shows the inverse of the last bit
  // Edges are kept off the core clock's sampling instant
  task automatic send(input logic [8:0] w, input int n);
    #5;
    for (int i = 0; i < n; i++) begin
      linkData = w[i];
      #40 linkClk = 1'b1;
      #80 linkClk = 1'b0;
      #40;
    end
    linkData = ~w[n-1];
  endtask : send
endmodule : usr_link_master

// >>> bench/usr_sync_rx_tb.sv
// Self-checking testbench of the synchronous slave receive path
`timescale 1ns/10ps
`include "usr_params.svh"

module usr_sync_rx_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic sleepIn = 1'b0;
  logic [9:0] avsAddress = 10'h000;
  logic [31:0] avsWriteData = 32'h00000000;
  logic [31:0] avsReadData;
  logic waitReq;
  logic irq;
  logic coreIrq;
  logic wakeOut;
  logic [12:0] irqVector;
  logic linkClk;
  logic linkData;
  logic [7:0] d;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  always #10 clk = ~clk;

  usr_sync_rx #(.DEPTH(2)) u_usr_sync_rx (
    .clk(clk), .arst_n(arst_n), .ce(1'b1),
    .avs_address(avsAddress), .avs_read(avsRead), .avs_write(avsWrite),
    .avs_byteenable(4'h1), .avs_writedata(avsWriteData),
    .avs_readdata(avsReadData), .avs_waitrequest(waitReq),
    .linkClk(linkClk), .linkData(linkData), .sleepIn(sleepIn),
    .irq(irq), .coreIrq(coreIrq), .wakeOut(wakeOut), .irqVector(irqVector)
  );

  usr_link_master u_usr_link_master (.linkClk(linkClk), .linkData(linkData));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk8

  task automatic chkPin(input string name, input logic [12:0] e, input logic [12:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chkPin

  // Request held until waitrequest is sampled low at a rising edge
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
    @(posedge clk);
    avsAddress <= {idx, 2'b00};
    avsRead <= ~wr;
    avsWrite <= wr;
    avsWriteData <= {24'h000000, wd};
    @(posedge clk);
    while (waitReq !== 1'b0) @(posedge clk);
    rd = avsReadData[7:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : access

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    access(1'b1, idx, wd, d);
  endtask : wr

  task automatic rdChk(input string name, input logic [7:0] idx, input logic [7:0] e);
    access(1'b0, idx, 8'h00, d);
    chk8(name, e, d);
  endtask : rdChk

  task automatic word(input logic [8:0] w, input int n);
    u_usr_link_master.send(w, n);
    repeat (10) @(posedge clk);
  endtask : word

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rdChk("intctl", `USR_IDX_INTCTL, 8'h00);
    rdChk("tstat", `USR_IDX_TSTAT, 8'h02);
    rdChk("unmapped", 8'h40, 8'h00);
    wr(`USR_IDX_TSTAT, 8'h10);
    rdChk("tstat", `USR_IDX_TSTAT, 8'h12);
    wr(`USR_IDX_PIEN, 8'h20);
    wr(`USR_IDX_INTCTL, 8'hc0);
    wr(`USR_IDX_EVEN, 8'h03);
    wr(`USR_IDX_RSTAT, 8'hb0);
    sleepIn <= 1'b1;
    word(9'h0a5, 8);
    rdChk("flag", `USR_IDX_PIRF, 8'h20);
    chkPin("coreIrq", 13'h0001, 13'(coreIrq));
    chkPin("vector", 13'h0004, irqVector);
    chkPin("wake", 13'h0001, 13'(wakeOut));
    chkPin("irq", 13'h0001, 13'(irq));
    rdChk("rstat", `USR_IDX_RSTAT, 8'hb0);
    rdChk("data", `USR_IDX_RDATA, 8'ha5);
    sleepIn <= 1'b0;
    wr(`USR_IDX_PIRF, 8'h20);
    rdChk("flag", `USR_IDX_PIRF, 8'h00);
    chkPin("coreIrq", 13'h0000, 13'(coreIrq));
    chkPin("vector", 13'h0000, irqVector);
    chkPin("wake", 13'h0000, 13'(wakeOut));
    wr(`USR_IDX_EVCLR, 8'h03);
    rdChk("evst", `USR_IDX_EVST, 8'h00);
    chkPin("irq", 13'h0000, 13'(irq));
    wr(`USR_IDX_RSTAT, 8'hd0);
    word(9'h1c3, 9);
    word(9'h03c, 9);
    rdChk("rstat", `USR_IDX_RSTAT, 8'hd1);
    rdChk("data", `USR_IDX_RDATA, 8'hc3);
    rdChk("rstat", `USR_IDX_RSTAT, 8'hd0);
    rdChk("data", `USR_IDX_RDATA, 8'h3c);
    wr(`USR_IDX_RSTAT, 8'h90);
    word(9'h011, 8);
    word(9'h022, 8);
    word(9'h033, 8);
    rdChk("rstat", `USR_IDX_RSTAT, 8'h92);
    rdChk("evst", `USR_IDX_EVST, 8'h03);
    chkPin("irq", 13'h0001, 13'(irq));
    rdChk("data", `USR_IDX_RDATA, 8'h11);
    rdChk("data", `USR_IDX_RDATA, 8'h22);
    word(9'h044, 8);
    rdChk("flag", `USR_IDX_PIRF, 8'h00);
    rdChk("data", `USR_IDX_RDATA, 8'h00);
    wr(`USR_IDX_RSTAT, 8'h80);
    rdChk("rstat", `USR_IDX_RSTAT, 8'h80);
    wr(`USR_IDX_RSTAT, 8'h90);
    word(9'h066, 8);
    rdChk("data", `USR_IDX_RDATA, 8'h66);
    wr(`USR_IDX_RSTAT, 8'h80);
    word(9'h055, 8);
    rdChk("flag", `USR_IDX_PIRF, 8'h00);
    wr(`USR_IDX_RSTAT, 8'h10);
    word(9'h077, 8);
    rdChk("flag", `USR_IDX_PIRF, 8'h00);
    wr(`USR_IDX_TSTAT, 8'h90);
    rdChk("tstat", `USR_IDX_TSTAT, 8'h92);
    wr(`USR_IDX_RSTAT, 8'h90);
    word(9'h088, 8);
    rdChk("flag", `USR_IDX_PIRF, 8'h00);
    stop_test();
  end
endmodule : usr_sync_rx_tb
